// File: ccs_pkg.sv
package ccs_pkg;
  // Mode codes sampled at reset
  localparam logic [2:0] MODE_X4 = 3'h7;
  localparam logic [2:0] MODE_X3 = 3'h6;
  localparam logic [2:0] MODE_X2 = 3'h5;
  localparam logic [2:0] MODE_X5 = 3'h4;
  localparam logic [2:0] MODE_DIRECT = 3'h3;
  localparam logic [2:0] MODE_X1P5 = 3'h2;
  localparam logic [2:0] MODE_PRESCALE = 3'h1;
  localparam logic [2:0] MODE_X2P5 = 3'h0;
  localparam logic [2:0] MODE_RESET = 3'h7;
  // Factor F in half units (x4 -> 8)
  localparam logic [3:0] HALF_X4 = 4'h8;
  localparam logic [3:0] HALF_X3 = 4'h6;
  localparam logic [3:0] HALF_X2 = 4'h4;
  localparam logic [3:0] HALF_X5 = 4'hA;
  localparam logic [3:0] HALF_X1P5 = 4'h3;
  localparam logic [3:0] HALF_X2P5 = 4'h5;
  localparam logic [3:0] HALF_X1 = 4'h2;
  // Watchdog-disable bit of the system configuration register
  localparam int OWD_DISABLE_BIT = 4;
  localparam int WDOG_OVERFLOW = 16;
  localparam int SRC_SEL_W = 2;
  localparam logic [1:0] SRC_DIRECT = 2'h0;
  localparam logic [1:0] SRC_PRESCALE = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [1:0] SRC_FREERUN = 2'h3;
endpackage

// File: ccs_clock_source.sv
module ccs_clock_source #(
  parameter int OVF_COUNT = ccs_pkg::WDOG_OVERFLOW
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pins and timing ticks, synchronous to mclk
  input wire logic [2:0] clockModeSelectPins,
  input wire logic oscillatorInputPin,
  input wire logic pllFreeRunTick,
  // Software write to system configuration register
  input wire logic sysConfigWrite,
  input wire logic [15:0] sysConfigData,
  // Clock source control
  output logic [1:0] cpuClockSource,
  output logic pllEnable,
  output logic pllFreeRun,
  output logic [3:0] pllFactorHalf,
  output logic pllResyncPulse,
  output logic prescaleClock,
  output logic oscWatchdogDisable,
  output logic oscFailInterruptRequest,
  output logic [2:0] capturedMode
);

  // ==========================================
  // State
  typedef struct packed {
    logic captured;
    logic [2:0] mode;
    logic owdDisable;
    logic [4:0] wdCount;
    logic failed;
    logic irq;
    logic oscLast;
    logic [3:0] edgeCount;
    logic resync;
    logic prescale;
    logic [1:0] source;
    logic pllOn;
    logic freeRun;
    logic [3:0] factor;
  } ccs_state_t;

  ccs_state_t cur;
  ccs_state_t next_cur;

  function automatic logic [3:0] ccsFactor(input logic [2:0] m);
    logic [3:0] f;
    f = ccs_pkg::HALF_X1;
    unique case (m)
      ccs_pkg::MODE_X4: f = ccs_pkg::HALF_X4;
      ccs_pkg::MODE_X3: f = ccs_pkg::HALF_X3;
      ccs_pkg::MODE_X2: f = ccs_pkg::HALF_X2;
      ccs_pkg::MODE_X5: f = ccs_pkg::HALF_X5;
      ccs_pkg::MODE_X1P5: f = ccs_pkg::HALF_X1P5;
      ccs_pkg::MODE_X2P5: f = ccs_pkg::HALF_X2P5;
      ccs_pkg::MODE_DIRECT: f = ccs_pkg::HALF_X1;
      ccs_pkg::MODE_PRESCALE: f = ccs_pkg::HALF_X1;
    endcase
    return f;
  endfunction

  // ==========================================
  // Next state
  always_comb begin
    logic oscEdge;
    logic [3:0] edgeTarget;
    logic direct;
    oscEdge = 1'b0;
    edgeTarget = 4'h1;
    direct = 1'b0;
    next_cur = cur;

    // ==========================================
    // Mode capture
    // capture once
    if (!cur.captured) begin
      next_cur.captured = 1'b1;
      next_cur.mode = clockModeSelectPins;
    end
    next_cur.factor = ccsFactor(next_cur.mode);
    direct = next_cur.mode == ccs_pkg::MODE_DIRECT || next_cur.mode == ccs_pkg::MODE_PRESCALE;

    // ==========================================
    // Input transition detect
    // Any level change counts, so both edges of the input clear the watchdog
    oscEdge = oscillatorInputPin != cur.oscLast;
    next_cur.oscLast = oscillatorInputPin;

    // ==========================================
    // Software disable
    // disable bit
    if (sysConfigWrite && sysConfigData[ccs_pkg::OWD_DISABLE_BIT]) begin
      next_cur.owdDisable = 1'b1;
    end

    // ==========================================
    // Watchdog counter
    // clear on edge
    if (oscEdge) begin
      next_cur.wdCount = '0;
    end else if (!cur.owdDisable && !cur.failed && pllFreeRunTick) begin
      next_cur.wdCount = cur.wdCount + 5'h01;
    end

    // ==========================================
    // Overflow
    // overflow after 16
    if (!cur.owdDisable && !cur.failed && !oscEdge && pllFreeRunTick
        && cur.wdCount == 5'(OVF_COUNT - 1)) begin
      next_cur.failed = 1'b1;
      next_cur.irq = 1'b1;
    end

    // ==========================================
    // Prescaler
    // divide by two
    if (oscEdge && oscillatorInputPin) begin
      next_cur.prescale = ~cur.prescale;
    end

    // ==========================================
    // Resynchronisation
    // resync every F-th transition
    if (!direct) begin
      edgeTarget = next_cur.factor;
    end
    next_cur.resync = 1'b0;
    if (oscEdge && !direct) begin
      if (cur.edgeCount + 4'h1 >= edgeTarget) begin
        next_cur.edgeCount = '0;
        next_cur.resync = 1'b1;
      end else begin
        next_cur.edgeCount = cur.edgeCount + 4'h1;
      end
    end

    // ==========================================
    // Source select
    // latch failed source
    if (next_cur.failed) begin
      next_cur.source = ccs_pkg::SRC_FREERUN;
      next_cur.pllOn = 1'b1;
      next_cur.freeRun = 1'b1;
    end else if (direct) begin
      if (next_cur.mode == ccs_pkg::MODE_PRESCALE) begin
        next_cur.source = ccs_pkg::SRC_PRESCALE;
      end else begin
        next_cur.source = ccs_pkg::SRC_DIRECT;
      end
      // PLL only kept alive to clock the watchdog
      next_cur.pllOn = !next_cur.owdDisable;
      next_cur.freeRun = !next_cur.owdDisable;
    end else begin
      next_cur.source = ccs_pkg::SRC_PLL;
      next_cur.pllOn = 1'b1;
      next_cur.freeRun = 1'b0;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{captured: 1'b0,
               mode: ccs_pkg::MODE_RESET,
               owdDisable: 1'b0,
               wdCount: 5'h00,
               failed: 1'b0,
               irq: 1'b0,
               oscLast: 1'b0,
               edgeCount: 4'h0,
               resync: 1'b0,
               prescale: 1'b0,
               source: ccs_pkg::SRC_DIRECT,
               pllOn: 1'b1,
               freeRun: 1'b1,
               factor: ccs_pkg::HALF_X4};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================
  // Outputs
  assign cpuClockSource = cur.source;
  assign pllEnable = cur.pllOn;
  assign pllFreeRun = cur.freeRun;
  assign pllFactorHalf = cur.factor;
  assign pllResyncPulse = cur.resync;
  assign prescaleClock = cur.prescale;
  assign oscWatchdogDisable = cur.owdDisable;
  assign oscFailInterruptRequest = cur.irq;
  assign capturedMode = cur.mode;

endmodule

// File: ccs_clock_source_props.sv
module ccs_clock_source_props #(parameter int OVF_COUNT = 16) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Inputs
  input wire logic oscillatorInputPin,
  input wire logic pllFreeRunTick,
  input wire logic sysConfigWrite,
  input wire logic [15:0] sysConfigData,
  // Outputs
  input wire logic [1:0] cpuClockSource,
  input wire logic pllEnable,
  input wire logic oscWatchdogDisable,
  input wire logic oscFailInterruptRequest,
  input wire logic [2:0] capturedMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Free-run ticks since the last pin change
  logic [7:0] quiet;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) quiet <= 8'h00;
    else quiet <= (oscillatorInputPin != $past(oscillatorInputPin)) ? 8'h00 : quiet + 8'(pllFreeRunTick);
  end
  sequence s_fail;
    $rose(oscFailInterruptRequest);
  endsequence
  chk_fail_switch: assert property (s_fail |-> cpuClockSource == 2'h3) else $error("no switch");
  chk_fail_late: assert property (s_fail |-> quiet >= OVF_COUNT - 1) else $error("early fail");
  chk_fail_due: assert property (quiet == OVF_COUNT + 2 && !oscWatchdogDisable |-> oscFailInterruptRequest)
    else $error("no fail");
  chk_irq_hold: assert property (oscFailInterruptRequest |=> oscFailInterruptRequest) else $error("irq lost");
  chk_src_hold: assert property (cpuClockSource == 2'h3 |=> cpuClockSource == 2'h3) else $error("src lost");
  chk_dis_set: assert property (sysConfigWrite && sysConfigData[4] |=> oscWatchdogDisable) else $error("no dis");
  chk_dis_hold: assert property (oscWatchdogDisable |=> oscWatchdogDisable) else $error("dis lost");
  chk_pll_off: assert property (oscWatchdogDisable && $past(oscWatchdogDisable) && !oscFailInterruptRequest
    && capturedMode == 3'h3 |-> !pllEnable) else $error("pll on");
endmodule
bind ccs_clock_source ccs_clock_source_props #(.OVF_COUNT(OVF_COUNT)) i_props (.mclk, .arst_n, .oscillatorInputPin,
  .pllFreeRunTick, .sysConfigWrite, .sysConfigData, .cpuClockSource, .pllEnable, .oscWatchdogDisable,
  .oscFailInterruptRequest, .capturedMode);

// File: ccs_osc_model.sv
module ccs_osc_model (
  // Clock and control
  input wire logic mclk,
  input wire logic run,
  // Oscillator level
  output logic osc = 1'b0
);
  // A stopped source holds its level
  always @(posedge mclk) if (run) osc <= ~osc;
endmodule

// File: test_cpu_clock_source_and_osc_watchdog.sv
module test_cpu_clock_source_and_osc_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %s exp %0h got %0h", n, e, a); end end
  logic mclk = 1'b0, arst_n = 1'b0, run = 1'b1, tick = 1'b1, wr = 1'b0, osc, pllEn, irq, dis;
  logic [2:0] pins = 3'h7;
  logic [15:0] data = 16'h0000;
  logic [1:0] src;
  logic fr, presc, resync, p;
  logic [2:0] mode;
  int cnt;
  logic [3:0] fac;
  int mismatches = 0, num_checks = 0;
  typedef struct packed {logic [2:0] m; logic [1:0] s; logic [3:0] f;} ccs_row_t;
  // Mode code, expected source, expected factor in half units
  ccs_row_t rows [8] = '{'{7, 2, 8}, '{6, 2, 6}, '{5, 2, 4}, '{4, 2, 10}, '{3, 0, 0}, '{2, 2, 3}, '{1, 1, 0}, '{0, 2, 5}};
  always #5 mclk = ~mclk;
  ccs_osc_model i_osc (.mclk, .run, .osc);
  ccs_clock_source #(.OVF_COUNT(4)) i_dut (.mclk, .arst_n, .clockModeSelectPins(pins), .oscillatorInputPin(osc),
    .pllFreeRunTick(tick), .sysConfigWrite(wr), .sysConfigData(data), .cpuClockSource(src), .pllEnable(pllEn),
    .pllFreeRun(fr), .pllFactorHalf(fac), .pllResyncPulse(resync), .prescaleClock(presc), .oscWatchdogDisable(dis),
    .oscFailInterruptRequest(irq), .capturedMode(mode));
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rst(logic [2:0] m);
    arst_n <= 1'b0;
    pins <= m;
    cyc(6);
    arst_n <= 1'b1;
    cyc(3);
  endtask
  task automatic cfg(logic [15:0] d);
    wr <= 1'b1;
    data <= d;
    cyc(1);
    wr <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      rst(rows[i].m);
      cyc(20);
      `CHK("src", rows[i].s, src)
      if (rows[i].s == 2'h2) `CHK("factor", rows[i].f, fac)
      `CHK("irq", 1'b0, irq)
      `CHK("dis", 1'b0, dis)
      `CHK("mode", rows[i].m, mode)
      `CHK("freerun", rows[i].s != 2'h2, fr)
      // Input toggles every cycle, so 120 cycles hold exactly 120/F pulses
      cnt = 0;
      repeat (120) begin
        @(negedge mclk);
        cnt += int'(resync);
      end
      `CHK("resync", (rows[i].s == 2'h2) ? 120 / int'(rows[i].f) : 0, cnt)
      p = presc;
      repeat (2) @(negedge mclk);
      `CHK("presc", ~p, presc)
      @(posedge mclk);
      $display("mode %0h done", rows[i].m);
    end
    // Stopped source in the last multiplied mode, then it comes back
    run <= 1'b0;
    cyc(8);
    `CHK("irq", 1'b1, irq)
    `CHK("src", 2'h3, src)
    `CHK("freerun", 1'b1, fr)
    run <= 1'b1;
    cyc(10);
    `CHK("src", 2'h3, src)
    rst(3'h3);
    `CHK("src", 2'h0, src)
    $display("failover done");
    cfg(16'h0010);
    run <= 1'b0;
    cyc(12);
    `CHK("irq", 1'b0, irq)
    `CHK("pll", 1'b0, pllEn)
    `CHK("src", 2'h0, src)
    cfg(16'h0000);
    cyc(2);
    `CHK("dis", 1'b1, dis)
    $display("disable done");
    wrap_up();
  end
  initial begin
    #50us;
    mismatches++;
    wrap_up();
  end
endmodule
